// ==== hdl/tbp_pkg.sv ====
// Package: register map, field positions and reset values of the port block
package tbp_pkg;

  localparam int unsigned ADDR_W = 4;

  localparam logic [3:0] ADDR_PIN_VALUE     = 4'h0;
  localparam logic [3:0] ADDR_OUTPUT_LATCH  = 4'h1;
  localparam logic [3:0] ADDR_DIRECTION     = 4'h2;
  localparam logic [3:0] ADDR_ANALOG_SELECT = 4'h3;
  localparam logic [3:0] ADDR_PMP_CONTROL   = 4'h4;

  localparam int unsigned NUM_PINS        = 3;
  localparam int unsigned OWN_PULLUP_BIT  = 6;
  localparam int unsigned NEIGH_PULLUP_BIT = 7;
  // Analog select bits for the three port pins in the analog select register
  localparam int unsigned ANALOG_SEL_LSB  = 5;
  localparam int unsigned PMP_OWN_BIT     = 0;

  localparam logic [2:0] DIRECTION_RESET = 3'h7;
  localparam logic [2:0] LATCH_RESET     = 3'h0;
  localparam logic [7:0] ANALOG_RESET    = 8'hff;
  localparam logic       PULLUP_RESET    = 1'h0;
  localparam logic       PMP_RESET       = 1'h0;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tbp_bus_s;

  typedef struct packed {
    logic [2:0] strobe_out;
    logic [2:0] strobe_oe;
  } tbp_pmp_s;

endpackage : tbp_pkg

// ==== hdl/tbp_sync.sv ====
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ns
`default_nettype none
module tbp_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule : tbp_sync
`default_nettype wire

// ==== hdl/tbp_port.sv ====
// Three-pin general purpose port with analog and parallel-port sharing
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - three pins, each input or output
// - analog pins read zero in pin value
// - direction bit one tristates the driver
// - direction bit zero drives latch bit
// - direction still rules analog pins
// - reset makes all three pins analog
// - latch reads return latch, not pins
// - bit six enables own pull-ups on input pins
// - output pins lose their pull-up
// - reset disables the pull-ups
// - analog blocks input path, not output
// - parallel port drives strobes on pins zero-two, reads strobes from pins zero-one
// - bit seven enables neighbour port pull-ups
// - unimplemented bits read zero
module tbp_port
  import tbp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       write,
  input  wire logic       read,
  output var  logic [7:0] rdata,
  input  wire logic [2:0] pin_in,
  output var  logic [2:0] pin_out,
  output var  logic [2:0] pin_oe,
  output var  logic [2:0] pin_pullup,
  output var  logic [2:0] adc_channel_enable,
  output var  logic       neighbour_pullup_enable,
  input  wire logic [2:0] pmp_strobe_out,
  input  wire logic [2:0] pmp_strobe_oe,
  output var  logic [1:0] pmp_strobe_in
);

  logic [2:0] latch;
  logic [2:0] direction;
  logic [7:0] analog_select;
  logic       own_pullup_enable;
  logic       pmp_own;
  logic [2:0] pin_sync;
  logic [2:0] analog_pins;
  logic [2:0] digital_in;
  logic [2:0] next_pin_out;
  logic [2:0] next_pin_oe;
  logic [7:0] next_rdata;
  tbp_pmp_s   pmp;

  function automatic logic hit(input logic [3:0] a,
                               input logic [3:0] target);
    return a == target;
  endfunction : hit

  assign pmp.strobe_out = pmp_strobe_out;
  assign pmp.strobe_oe  = pmp_strobe_oe;

  tbp_sync #(.WIDTH(NUM_PINS)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  assign analog_pins = analog_select[ANALOG_SEL_LSB +: NUM_PINS];
  // Analog pins have their digital input buffer off
  assign digital_in  = pin_sync & ~analog_pins;

  // Latch register, written at both the pin value and latch addresses
  always_ff @(posedge clk) begin
    if (reset) begin
      latch <= LATCH_RESET;
    end else if (write && (hit(addr, ADDR_OUTPUT_LATCH) ||
                           hit(addr, ADDR_PIN_VALUE))) begin
      latch <= wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      direction <= DIRECTION_RESET;
    end else if (write && hit(addr, ADDR_DIRECTION)) begin
      direction <= wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      analog_select <= ANALOG_RESET;
    end else if (write && hit(addr, ADDR_ANALOG_SELECT)) begin
      analog_select <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      own_pullup_enable       <= PULLUP_RESET;
      neighbour_pullup_enable <= PULLUP_RESET;
    end else if (write && hit(addr, ADDR_PIN_VALUE)) begin
      own_pullup_enable       <= wdata[OWN_PULLUP_BIT];
      neighbour_pullup_enable <= wdata[NEIGH_PULLUP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pmp_own <= PMP_RESET;
    end else if (write && hit(addr, ADDR_PMP_CONTROL)) begin
      pmp_own <= wdata[PMP_OWN_BIT];
    end
  end

  // Driver: latch unless the parallel port owns the pins; analog select
  // never touches the output path, so software must keep analog pins input
  always_comb begin
    if (pmp_own) begin
      next_pin_out = pmp.strobe_out;
      next_pin_oe  = pmp.strobe_oe;
    end else begin
      next_pin_out = latch;
      next_pin_oe  = ~direction;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out            <= LATCH_RESET;
      pin_oe             <= '0;
      pin_pullup         <= '0;
      adc_channel_enable <= DIRECTION_RESET;
      pmp_strobe_in      <= '0;
    end else begin
      pin_out            <= next_pin_out;
      pin_oe             <= next_pin_oe;
      pin_pullup         <= {NUM_PINS{own_pullup_enable}} & ~next_pin_oe;
      adc_channel_enable <= analog_pins;
      pmp_strobe_in      <= digital_in[1:0];
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      ADDR_PIN_VALUE:     next_rdata = {neighbour_pullup_enable,
                                        own_pullup_enable, 3'h0, digital_in};
      ADDR_OUTPUT_LATCH:  next_rdata = {5'h00, latch};
      ADDR_DIRECTION:     next_rdata = {5'h00, direction};
      ADDR_ANALOG_SELECT: next_rdata = analog_select;
      ADDR_PMP_CONTROL:   next_rdata = {7'h00, pmp_own};
      default:            next_rdata = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (read) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : tbp_port
`default_nettype wire

// ==== tb/tbp_port_properties.sv ====
// Checker for the port block
`timescale 1ns/1ns
`default_nettype none
module tbp_port_properties (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       write,
  input wire logic       read,
  input wire logic [7:0] rdata,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_pullup,
  input wire logic [2:0] adc_channel_enable,
  input wire logic       neighbour_pullup_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rst;
    $fell(reset) |-> !pin_pullup && adc_channel_enable == 3'h7;
  endproperty
  property p_idle; !read |=> rdata == 8'h0; endproperty
  property p_pad; read && addr inside {1, 2} |=> !rdata[7:3]; endproperty
  property p_ana;
    read && addr == 4'h0 |=> !(rdata[2:0] & adc_channel_enable);
  endproperty
  property p_dir;
    write && addr == 4'h2 |-> ##2 pin_oe == ~$past(wdata[2:0], 2);
  endproperty
  property p_out;
    write && addr == 4'h1 |-> ##2 !((pin_out ^ $past(wdata[2:0], 2)) & pin_oe);
  endproperty
  property p_pu;
    write && addr == 4'h0 |-> ##2
      pin_pullup == (~pin_oe & {3{$past(wdata[6], 2)}});
  endproperty
  property p_nb;
    write && addr == 4'h0 |-> ##2 neighbour_pullup_enable == $past(wdata[7], 2);
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  a_idle: assert property (p_idle) else $error("idle rdata");
  a_pad: assert property (p_pad) else $error("pad bits");
  a_ana: assert property (p_ana) else $error("analog read");
  a_dir: assert property (p_dir) else $error("direction");
  a_out: assert property (p_out) else $error("latch drive");
  a_pu: assert property (p_pu) else $error("pull-up");
  a_nb: assert property (p_nb) else $error("neighbour");
  cover property (write && addr == 4'h2);
  cover property (read && addr == 4'h0);
  cover property (write && addr == 4'h0 && wdata[6]);
endmodule : tbp_port_properties
bind tbp_port tbp_port_properties u_chk (.*);
`default_nettype wire

// ==== tb/tbp_board.sv ====
// Board model: external drivers and pull-ups on the three pins
`timescale 1ns/1ns
`default_nettype none
module tbp_board (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pin_pullup,
  input  wire logic [2:0] ext_val,
  input  wire logic [2:0] ext_en,
  output var  logic [2:0] pin_in
);
  // A floating pad shows the inverse level so a stale value cannot pass
  always_comb
    for (int i = 0; i < 3; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pin_pullup[i] | ~pin_out[i];
endmodule : tbp_board
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the three-pin port
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tbp_pkg::*;
  logic clk = 0, reset = 1, write = 0, read = 0, neighbour_pullup_enable;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, rdata, v;
  logic [2:0] pin_in, pin_out, pin_oe, pin_pullup, adc_channel_enable;
  logic [2:0] ext_val = 0, ext_en = 3'h7, pmp_strobe_out = 0;
  logic [2:0] pmp_strobe_oe = 0;
  logic [1:0] pmp_strobe_in;
  int err_count = 0, num_checks = 0;
  tbp_port uut (.*);
  tbp_board brd (.*);
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    write <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    read <= 1'h1;
    addr <= a;
    @(posedge clk);
    read <= 1'h0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    void'($urandom(32'h961f));
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    rd(ADDR_DIRECTION, 8'h07);
    rd(ADDR_ANALOG_SELECT, ANALOG_RESET);
    rd(ADDR_PIN_VALUE, 8'h00);
    rd(4'hf, 8'h00);
    $display("reset test done");
    wr(ADDR_ANALOG_SELECT, 8'h1f);
    repeat (20) begin
      v = 8'($urandom);
      ext_val <= ~v[2:0];
      wr(ADDR_OUTPUT_LATCH, v);
      wr(ADDR_DIRECTION, ~v);
      rd(ADDR_OUTPUT_LATCH, v & 8'h07);
      rd(ADDR_DIRECTION, ~v & 8'h07);
      // Outputs drive ones, inputs see ones from the board
      rd(ADDR_PIN_VALUE, 8'h07);
      chk({5'h0, pin_oe}, v & 8'h07);
    end
    $display("direction test done");
    ext_en <= 3'h0;
    wr(ADDR_PIN_VALUE, 8'hc0);
    repeat (2) @(posedge clk);
    #1 chk({5'h0, pin_pullup}, {5'h0, ~v[2:0]});
    rd(ADDR_PIN_VALUE, {2'h3, 3'h0, ~v[2:0]});
    $display("pull-up test done");
    ext_en <= 3'h7;
    wr(ADDR_PIN_VALUE, 8'h00);
    wr(ADDR_ANALOG_SELECT, 8'hff);
    wr(ADDR_OUTPUT_LATCH, 8'h05);
    wr(ADDR_DIRECTION, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk({2'h0, pin_oe, pin_out}, 8'h3d);
    rd(ADDR_PIN_VALUE, 8'h00);
    wr(ADDR_DIRECTION, 8'hff);
    repeat (2) @(posedge clk);
    #1 chk({5'h0, pin_oe}, 8'h00);
    $display("analog test done");
    ext_val <= 3'h2;
    wr(ADDR_ANALOG_SELECT, 8'h1f);
    pmp_strobe_out <= 3'h4;
    pmp_strobe_oe <= 3'h4;
    wr(ADDR_PMP_CONTROL, 8'h01);
    repeat (4) @(posedge clk);
    #1 chk({2'h0, pin_oe, pin_out}, 8'h24);
    chk({6'h0, pmp_strobe_in}, 8'h02);
    $display("pmp test done");
    results();
  end
endmodule : tb
`default_nettype wire
